/* rtl/tccm_pkg.sv */
// constants for the capture/compare mode configuration block
package tccm_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, low eight bits decoded)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] TRIG_SELECT_OFFSET = 8'h08;
  localparam logic [7:0] MODE_OFFSET = 8'h18;
  localparam logic [7:0] ENABLE_OFFSET = 8'h20;
  localparam logic [7:0] STATUS_OFFSET = 8'h44;

  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [5:0] ENABLE_RESET = 6'h00;
  localparam logic [2:0] TRIG_SELECT_RESET = 3'h0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DIR_W = 2;
  localparam int FILT_W = 4;
  localparam int PSC_W = 2;
  localparam int OCMODE_W = 3;
  localparam int MODE_W = 16;
  localparam int ENABLE_W = 6;
  localparam int TRIG_SEL_W = 3;
  localparam int CH1_DIR_LSB = 0;
  localparam int CH1_FEN_BIT = 2;
  localparam int CH1_OCMODE_LSB = 4;
  localparam int CH1_PSC_LSB = 2;
  localparam int CH1_FILT_LSB = 4;
  localparam int CH2_DIR_LSB = 8;
  localparam int CH2_PSC_LSB = 10;
  localparam int CH2_FILT_LSB = 12;
  localparam int CH1_EN_BIT = 0;
  localparam int CH1_POL_BIT = 1;
  localparam int CH2_EN_BIT = 4;
  localparam int CH2_POL_BIT = 5;
  // trigger select values with this bit low name an internal trigger
  localparam int TRIG_SEL_EXT_BIT = 2;

  // ---------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------
  localparam logic [1:0] DIR_OUTPUT = 2'h0;
  localparam logic [1:0] DIR_OWN_INPUT = 2'h1;
  localparam logic [1:0] DIR_NEIGHBOUR = 2'h2;
  localparam logic [1:0] DIR_TRIGGER = 2'h3;
  localparam logic [2:0] OCMODE_PWM_ONE = 3'h6;
  localparam logic [2:0] OCMODE_PWM_TWO = 3'h7;
  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ---------------------------------------------------------------
  // timing, in clock cycles from the trigger edge
  // ---------------------------------------------------------------
  localparam int TRIG_NORMAL_CYC = 5;
  localparam int TRIG_FAST_CYC = 3;
  localparam int TRIG_PIPE_W = TRIG_NORMAL_CYC - 1;

  // ---------------------------------------------------------------
  // filter table: event count and log2 of the sampling divider, then the prescaler masks
  // ---------------------------------------------------------------
  localparam int DIV_W = 5;
  localparam logic [3:0] FILT_N [16] = '{
    4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'h8, 4'h6, 4'h8,
    4'h6, 4'h8, 4'h5, 4'h6, 4'h8, 4'h5, 4'h6, 4'h8};
  localparam logic [2:0] FILT_EXP [16] = '{
    3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2,
    3'h3, 3'h3, 3'h4, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5};
  localparam logic [2:0] PSC_MASK [4] = '{3'h0, 3'h1, 3'h3, 3'h7};

endpackage : tccm_pkg

/* rtl/tccm_input_filter.sv */
// digital event-counting filter for one capture channel
`timescale 1ns/1ns
module tccm_input_filter (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // configuration
  input wire logic [3:0] filtCode,
  input wire logic [tccm_pkg::DIV_W-1:0] divCnt,
  // data
  input wire logic dataIn,
  output logic dataOut
);

  // ---------------------------------------------------------------
  // sample tick and required count
  // ---------------------------------------------------------------
  logic [3:0] needN;
  logic [2:0] divExp;
  logic [tccm_pkg::DIV_W-1:0] divMask;
  logic sampleTick;
  logic differs;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic out_q;
  logic out_d;

  assign needN = tccm_pkg::FILT_N[filtCode];
  assign divExp = tccm_pkg::FILT_EXP[filtCode];
  // RULE11 RULE12 RULE13 RULE14 sampling rate per code
  assign divMask = ~({tccm_pkg::DIV_W{1'b1}} << divExp);
  assign sampleTick = (divCnt & divMask) == divMask;
  assign differs = dataIn != out_q;

  // RULE10 count N samples at the new level
  assign cnt_d = !sampleTick ? cnt_q :
                 !differs ? 4'h0 :
                 (cnt_q == needN - 4'h1) ? 4'h0 : cnt_q + 4'h1;
  assign out_d = (sampleTick && differs && cnt_q == needN - 4'h1) ?
                 dataIn : out_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign dataOut = out_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_filter_count: assert property (@(posedge clk) disable iff (!rstn) // RULE10
    (out_q != $past(out_q)) |-> ($past(cnt_q) == $past(needN) - 4'h1))
    else $error("filter output moved before N events");
  a_filter_bypass: assert property (@(posedge clk) disable iff (!rstn) // RULE11
    (filtCode == 4'h0) |=> (out_q == $past(dataIn)))
    else $error("unfiltered input not passed in one cycle");

endmodule : tccm_input_filter

/* rtl/tccm_mode_config.sv */
// capture/compare mode configuration for two timer channels
// -----------------------------------------------------------------
// Overview of operation
// RULE1 - normal trigger to output takes five cycles
// RULE2 - fast trigger edge acts as compare match
// RULE3 - fast trigger to output takes three cycles
// RULE4 - fast response only in pulse width modes
// RULE5 - fast enable bit 2, direction bits 1:0
// RULE6 - channel 1 select: output, own, neighbour, trigger
// RULE7 - channel 2 select: output, own, neighbour, trigger
// RULE8 - trigger mapping needs internal trigger selected
// RULE9 - direction writable only while channel disabled
// RULE10 - filter flips after N events at level
// RULE11 - code zero: no filter, sampling clock rate
// RULE12 - codes 1-3: timer clock, N 2/4/8
// RULE13 - codes 4-9: divide 2/4/8, N 6/8
// RULE14 - codes 10-15: divide 16/32, N 5/6/8
// RULE15 - prescaler captures every 1/2/4/8 events
// RULE16 - prescaler counter cleared while channel disabled
// RULE17 - input layout fields at documented bit positions
// RULE18 - field meaning follows channel direction
// RULE19 - modes 110 and 111 are pulse width
// RULE20 - channel 2 filters and prescales like channel 1
// -----------------------------------------------------------------
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
module tccm_mode_config (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // timer input pins
  input wire logic timerInputOne,
  input wire logic timerInputTwo,
  // internal trigger and timer core
  input wire logic internalTriggerCaptureSource,
  input wire logic ch1CompareLevel,
  input wire logic ch1MatchLevel,
  // towards the timer core
  output logic ch1OcRef,
  output logic triggerStart,
  output logic ch1Capture,
  output logic ch2Capture
);

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic [15:0] mode_q, mode_d;
  logic [5:0] enable_q, enable_d;
  logic [2:0] trigSel_q, trigSel_d;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] rdata_q, rdata_d, readMux;
  logic busAccept, modeWr, enableWr, trigSelWr;
  logic [15:0] statusWord;
  logic [7:0] accAddr;

  assign accAddr = haddr[tccm_pkg::ADDR_W-1:0];
  // only single aligned word transfers are meant to reach here
  assign busAccept = hsel && hready && htrans[1] &&
                     (hsize == tccm_pkg::HSIZE_WORD);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  assign modeWr = wrPend_q && wrAddr_q == tccm_pkg::MODE_OFFSET;
  assign enableWr = wrPend_q && wrAddr_q == tccm_pkg::ENABLE_OFFSET;
  assign trigSelWr = wrPend_q && wrAddr_q == tccm_pkg::TRIG_SELECT_OFFSET;

  assign readMux =
    (accAddr == tccm_pkg::MODE_OFFSET) ? {16'h0000, mode_q} :
    (accAddr == tccm_pkg::ENABLE_OFFSET) ? {26'h0, enable_q} :
    (accAddr == tccm_pkg::TRIG_SELECT_OFFSET) ? {29'h0, trigSel_q} :
    (accAddr == tccm_pkg::STATUS_OFFSET) ? {16'h0000, statusWord} :
    32'h00000000;
  assign rdata_d = (busAccept && !hwrite) ? readMux : 32'h00000000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      wrPend_q <= busAccept && hwrite;
      wrAddr_q <= accAddr;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic ch1Enable;
  logic ch2Enable;
  logic [1:0] ch1Dir;
  logic [1:0] ch2Dir;

  assign ch1Enable = enable_q[tccm_pkg::CH1_EN_BIT];
  assign ch2Enable = enable_q[tccm_pkg::CH2_EN_BIT];
  assign ch1Dir = mode_q[tccm_pkg::CH1_DIR_LSB +: tccm_pkg::DIR_W];
  assign ch2Dir = mode_q[tccm_pkg::CH2_DIR_LSB +: tccm_pkg::DIR_W];

  always_comb begin
    mode_d = mode_q;
    if (modeWr) begin
      mode_d = hwdata[tccm_pkg::MODE_W-1:0];
      // RULE9 direction locked while channel enabled
      if (ch1Enable) begin
        mode_d[tccm_pkg::CH1_DIR_LSB +: tccm_pkg::DIR_W] = ch1Dir;
      end
      if (ch2Enable) begin
        mode_d[tccm_pkg::CH2_DIR_LSB +: tccm_pkg::DIR_W] = ch2Dir;
      end
    end
  end

  assign enable_d = enableWr ? hwdata[tccm_pkg::ENABLE_W-1:0] : enable_q;
  assign trigSel_d = trigSelWr ? hwdata[tccm_pkg::TRIG_SEL_W-1:0] : trigSel_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= tccm_pkg::MODE_RESET;
      enable_q <= tccm_pkg::ENABLE_RESET;
      trigSel_q <= tccm_pkg::TRIG_SELECT_RESET;
    end else begin
      mode_q <= mode_d;
      enable_q <= enable_d;
      trigSel_q <= trigSel_d;
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] pinSync1_q;
  logic [1:0] pinSync2_q;
  logic [1:0] pinSync3_q;
  logic [1:0] pinStable_q;
  logic [1:0] pinStable_d;
  logic [1:0] pinAgree;

  // a change counts only once the second and third stages agree
  assign pinAgree = ~(pinSync2_q ^ pinSync3_q);
  assign pinStable_d = (pinAgree & pinSync3_q) | (~pinAgree & pinStable_q);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinSync1_q <= 2'h0;
      pinSync2_q <= 2'h0;
      pinSync3_q <= 2'h0;
      pinStable_q <= 2'h0;
    end else begin
      pinSync1_q <= {timerInputTwo, timerInputOne};
      pinSync2_q <= pinSync1_q;
      pinSync3_q <= pinSync2_q;
      pinStable_q <= pinStable_d;
    end
  end

  // ---------------------------------------------------------------
  // input mapping
  // ---------------------------------------------------------------
  logic trigInternal;
  logic trigSrcUsable;
  logic ch1Mapped;
  logic ch2Mapped;

  // RULE8 trigger mapping gated by trigger select
  assign trigInternal = !trigSel_q[tccm_pkg::TRIG_SEL_EXT_BIT];
  assign trigSrcUsable = trigInternal && internalTriggerCaptureSource;

  // RULE6 channel 1 input decode
  assign ch1Mapped =
    (ch1Dir == tccm_pkg::DIR_OWN_INPUT) ? pinStable_q[0] :
    (ch1Dir == tccm_pkg::DIR_NEIGHBOUR) ? pinStable_q[1] :
    (ch1Dir == tccm_pkg::DIR_TRIGGER) ? trigSrcUsable : 1'b0;
  // RULE7 channel 2 input decode
  assign ch2Mapped =
    (ch2Dir == tccm_pkg::DIR_OWN_INPUT) ? pinStable_q[1] :
    (ch2Dir == tccm_pkg::DIR_NEIGHBOUR) ? pinStable_q[0] :
    (ch2Dir == tccm_pkg::DIR_TRIGGER) ? trigSrcUsable : 1'b0;

  // ---------------------------------------------------------------
  // filters
  // ---------------------------------------------------------------
  logic [tccm_pkg::DIV_W-1:0] divCnt_q;
  logic ch1Filtered;
  logic ch2Filtered;

  // the sampling clock equals the timer clock here; one free divider
  // serves both channels so their sample instants line up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= divCnt_q + 1'b1;
    end
  end

  // RULE17 input layout field positions
  tccm_input_filter ch1Filter (
    .clk(clk),
    .rstn(rstn),
    .filtCode(mode_q[tccm_pkg::CH1_FILT_LSB +: tccm_pkg::FILT_W]),
    .divCnt(divCnt_q),
    .dataIn(ch1Mapped),
    .dataOut(ch1Filtered)
  );

  // RULE20 channel 2 filtered like channel 1
  tccm_input_filter ch2Filter (
    .clk(clk),
    .rstn(rstn),
    .filtCode(mode_q[tccm_pkg::CH2_FILT_LSB +: tccm_pkg::FILT_W]),
    .divCnt(divCnt_q),
    .dataIn(ch2Mapped),
    .dataOut(ch2Filtered)
  );

  // ---------------------------------------------------------------
  // edge detect and capture prescalers
  // ---------------------------------------------------------------
  logic [1:0] filtPrev_q, chEvent, chIsInput;
  logic [1:0] chEnableVec, chPol, filtNow;
  logic [2:0] psc1Mask, psc2Mask;
  logic [2:0] psc1Cnt_q, psc2Cnt_q, psc1Cnt_d, psc2Cnt_d;
  logic [1:0] capture_q, capture_d;

  assign filtNow = {ch2Filtered, ch1Filtered};
  assign chPol = {enable_q[tccm_pkg::CH2_POL_BIT],
                  enable_q[tccm_pkg::CH1_POL_BIT]};
  assign chEnableVec = {ch2Enable, ch1Enable};
  // RULE18 capture fields act only in input direction
  assign chIsInput = {ch2Dir != tccm_pkg::DIR_OUTPUT,
                      ch1Dir != tccm_pkg::DIR_OUTPUT};
  // polarity picks the rising or the falling edge
  assign chEvent = (filtNow ^ filtPrev_q) & ~(filtNow ^ ~chPol) &
                   chIsInput & chEnableVec;

  assign psc1Mask =
    tccm_pkg::PSC_MASK[mode_q[tccm_pkg::CH1_PSC_LSB +: tccm_pkg::PSC_W]];
  assign psc2Mask =
    tccm_pkg::PSC_MASK[mode_q[tccm_pkg::CH2_PSC_LSB +: tccm_pkg::PSC_W]];

  // RULE16 counter held clear while disabled
  // RULE15 capture once every 1, 2, 4 or 8 events
  assign psc1Cnt_d = !ch1Enable ? 3'h0 :
                     !chEvent[0] ? psc1Cnt_q :
                     (psc1Cnt_q >= psc1Mask) ? 3'h0 : psc1Cnt_q + 3'h1;
  // RULE20 channel 2 prescaled like channel 1
  assign psc2Cnt_d = !ch2Enable ? 3'h0 :
                     !chEvent[1] ? psc2Cnt_q :
                     (psc2Cnt_q >= psc2Mask) ? 3'h0 : psc2Cnt_q + 3'h1;
  assign capture_d = {chEvent[1] && psc2Cnt_q >= psc2Mask,
                      chEvent[0] && psc1Cnt_q >= psc1Mask};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      filtPrev_q <= 2'h0;
      psc1Cnt_q <= 3'h0;
      psc2Cnt_q <= 3'h0;
      capture_q <= 2'h0;
    end else begin
      filtPrev_q <= filtNow;
      psc1Cnt_q <= psc1Cnt_d;
      psc2Cnt_q <= psc2Cnt_d;
      capture_q <= capture_d;
    end
  end

  assign ch1Capture = capture_q[0];
  assign ch2Capture = capture_q[1];

  // ---------------------------------------------------------------
  // trigger response for channel 1 output
  // ---------------------------------------------------------------
  logic trigPrev_q;
  logic trigEdge;
  logic fastOn;
  logic ch1PwmMode;
  logic [tccm_pkg::TRIG_PIPE_W-1:0] trigPipe_q;
  logic [tccm_pkg::TRIG_PIPE_W-1:0] fastPipe_q;
  logic ocRef_q;
  logic ocRef_d;

  assign trigEdge = trigSrcUsable && !trigPrev_q;
  // RULE19 pulse width modes 110 and 111
  assign ch1PwmMode =
    mode_q[tccm_pkg::CH1_OCMODE_LSB +: tccm_pkg::OCMODE_W] ==
      tccm_pkg::OCMODE_PWM_ONE ||
    mode_q[tccm_pkg::CH1_OCMODE_LSB +: tccm_pkg::OCMODE_W] ==
      tccm_pkg::OCMODE_PWM_TWO;
  // RULE4 RULE5 RULE18 fast enable honoured in pwm output only
  assign fastOn = mode_q[tccm_pkg::CH1_FEN_BIT] && ch1PwmMode &&
                  ch1Dir == tccm_pkg::DIR_OUTPUT;

  // RULE2 RULE3 fast edge forces match level at cycle three
  // RULE1 otherwise the core's comparison drives the output
  assign ocRef_d = fastPipe_q[tccm_pkg::TRIG_FAST_CYC-2] ? ch1MatchLevel :
                   ch1CompareLevel;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trigPrev_q <= 1'b0;
      trigPipe_q <= '0;
      fastPipe_q <= '0;
      ocRef_q <= 1'b0;
    end else begin
      trigPrev_q <= trigSrcUsable;
      trigPipe_q <= {trigPipe_q[tccm_pkg::TRIG_PIPE_W-2:0], trigEdge};
      fastPipe_q <= {fastPipe_q[tccm_pkg::TRIG_PIPE_W-2:0],
                     trigEdge && fastOn};
      ocRef_q <= ocRef_d;
    end
  end

  // RULE1 core restart four cycles on, output on the fifth
  assign triggerStart = trigPipe_q[tccm_pkg::TRIG_PIPE_W-1];
  assign ch1OcRef = ocRef_q;

  // ---------------------------------------------------------------
  // status word
  // ---------------------------------------------------------------
  assign statusWord = {5'h00, fastOn, psc2Cnt_q, psc1Cnt_q,
                       pinStable_q, ch2Filtered, ch1Filtered};

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_normal_latency: assert property (@(posedge clk) disable iff (!rstn) // RULE1
    trigEdge |-> ##4 triggerStart)
    else $error("trigger start not four cycles after edge");
  a_fast_match: assert property (@(posedge clk) disable iff (!rstn) // RULE2
    (trigEdge && fastOn) |-> ##3 (ch1OcRef == $past(ch1MatchLevel)))
    else $error("fast edge did not force match level");
  a_fast_gate: assert property (@(posedge clk) disable iff (!rstn) // RULE4
    fastOn |-> (ch1PwmMode && ch1Dir == tccm_pkg::DIR_OUTPUT))
    else $error("fast response outside pwm output");
  a_dir_lock: assert property (@(posedge clk) disable iff (!rstn) // RULE9
    (modeWr && ch1Enable) |=> (ch1Dir == $past(ch1Dir)))
    else $error("direction changed while channel enabled");
  a_trc_gate: assert property (@(posedge clk) disable iff (!rstn) // RULE8
    (ch1Dir == tccm_pkg::DIR_TRIGGER && !trigInternal) |-> !ch1Mapped)
    else $error("trigger mapping active without internal select");
  a_ch2_map: assert property (@(posedge clk) disable iff (!rstn) // RULE7
    (ch2Dir == tccm_pkg::DIR_NEIGHBOUR) |-> (ch2Mapped == pinStable_q[0]))
    else $error("channel 2 neighbour mapping wrong");
  a_psc_clear: assert property (@(posedge clk) disable iff (!rstn) // RULE16
    !ch1Enable |=> (psc1Cnt_q == 3'h0))
    else $error("prescaler count kept while disabled");
  a_psc_ratio: assert property (@(posedge clk) disable iff (!rstn) // RULE15
    ch1Capture |-> ($past(psc1Cnt_q) == $past(psc1Mask)))
    else $error("capture taken at wrong prescaler count");

endmodule : tccm_mode_config

/* tb/tccm_pin_model.sv */
// partner model: timer input pins, internal trigger, core levels
`timescale 1ns/1ns
module tccm_pin_model (
  // clock
  input wire logic clk,
  // pins and internal trigger
  output logic pinOne,
  output logic pinTwo,
  output logic trigSrc,
  // core compare levels
  output logic cmpLevel,
  output logic matchLevel
);
  // compare evaluation rests low and a match is high, so a forced
  // match shows as a high reference output unless the bench moves it
  initial begin
    pinOne = 1'b0;
    pinTwo = 1'b0;
    trigSrc = 1'b0;
    cmpLevel = 1'b0;
    matchLevel = 1'b1;
  end

  task automatic setLine(input int which, input logic v);
    case (which)
      0: pinOne <= v;
      1: pinTwo <= v;
      3: cmpLevel <= v;
      default: trigSrc <= v;
    endcase
  endtask : setLine

  // high for len cycles, then low at least one cycle before returning
  task automatic pulse(input int which, input int len);
    setLine(which, 1'b1);
    repeat (len) @(posedge clk);
    setLine(which, 1'b0);
    @(posedge clk);
  endtask : pulse
endmodule : tccm_pin_model

/* tb/tccm_mode_config_tb.sv */
// self-checking bench for the capture/compare mode configuration
`timescale 1ns/1ns
`define CHK(nm, ex, sn) begin cmpCount++; if ((sn) !== (ex)) begin \
  badCount++; $display("mismatch %s exp %0h got %0h", nm, ex, sn); \
  end end
module tccm_mode_config_tb;
  localparam logic [7:0] aMode = tccm_pkg::MODE_OFFSET;
  localparam logic [7:0] aEn = tccm_pkg::ENABLE_OFFSET;
  localparam logic [7:0] aTrig = tccm_pkg::TRIG_SELECT_OFFSET;
  logic clk;
  logic rstn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic pinOne, pinTwo, trigSrc, cmpLevel, matchLevel;
  logic ch1OcRef, triggerStart, ch1Capture, ch2Capture;
  logic [31:0] rv;
  int badCount, cmpCount, cap1, cap2, oc, ts;
  int fc[3] = '{3, 9, 15};
  int sl[3] = '{5, 30, 100};
  int ll[3] = '{20, 100, 300};
  logic [15:0] fm[5] = '{16'h0060, 16'h0014, 16'h0074, 16'h0064,
    16'h0065};
  int fe[5] = '{0, 0, 3, 3, 0};

  tccm_pin_model pm (.clk(clk), .pinOne(pinOne), .pinTwo(pinTwo),
    .trigSrc(trigSrc), .cmpLevel(cmpLevel), .matchLevel(matchLevel));
  tccm_mode_config DUT (.clk(clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .timerInputOne(pinOne),
    .timerInputTwo(pinTwo), .internalTriggerCaptureSource(trigSrc),
    .ch1CompareLevel(cmpLevel), .ch1MatchLevel(matchLevel),
    .ch1OcRef(ch1OcRef), .triggerStart(triggerStart),
    .ch1Capture(ch1Capture), .ch2Capture(ch2Capture));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (ch1Capture === 1'b1) cap1++;
    if (ch2Capture === 1'b1) cap2++;
  end

  // ---------------------------------------------------------------
  // bus and stimulus tasks
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    `CHK("okay response", 1'b0, hresp)
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic setMode(input logic [15:0] m, input logic [31:0] en);
    wr(aEn, 32'h0);
    wr(aMode, {16'h0, m});
    wr(aEn, en);
  endtask : setMode

  // the wait after each pulse lets the falling edge clear the filter
  task automatic burst(input int which, input int len, input int reps,
      input int e1, input int e2);
    cap1 = 0;
    cap2 = 0;
    repeat (reps) begin
      pm.pulse(which, len);
      repeat (len + 30) @(posedge clk);
    end
    `CHK("cap1", e1, cap1)
    `CHK("cap2", e2, cap2)
  endtask : burst

  task automatic trigLat(output int o, output int t);
    o = 0;
    t = 0;
    fork
      pm.pulse(2, 6);
      for (int i = 1; i <= 6; i++) begin
        @(posedge clk);
        #1;
        if (o == 0 && ch1OcRef === 1'b1) o = i;
        if (t == 0 && triggerStart === 1'b1) t = i;
      end
    join
  endtask : trigLat

  task automatic wrapUp();
    $display("compares %0d, mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrapUp

  initial begin
    repeat (40000) @(posedge clk);
    badCount++;
    $display("watchdog expired");
    wrapUp();
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus(1'b0, aMode, 32'h0, rv);
    `CHK("mode reset", 32'h0, rv)
    bus(1'b0, aEn, 32'h0, rv);
    `CHK("enable reset", 32'h0, rv)
    wr(8'h30, 32'hffffffff);
    bus(1'b0, 8'h30, 32'h0, rv);
    `CHK("unmapped", 32'h0, rv)
    wr(aMode, 32'hffffffff);
    bus(1'b0, aMode, 32'h0, rv);
    `CHK("mode width", 32'h0000ffff, rv)
    wr(aMode, 32'h0);
    wr(aEn, 32'h1);
    wr(aMode, 32'h00f2);
    bus(1'b0, aMode, 32'h0, rv);
    `CHK("dir locked", 32'h00f0, rv)
    $display("test registers done");
    setMode(16'h0101, 32'h11);
    burst(0, 10, 1, 1, 0);
    burst(1, 10, 1, 0, 1);
    setMode(16'h0202, 32'h11);
    burst(0, 10, 1, 0, 1);
    burst(1, 10, 1, 1, 0);
    wr(aTrig, 32'h4);
    setMode(16'h0303, 32'h11);
    burst(2, 10, 1, 0, 0);
    wr(aTrig, 32'h0);
    burst(2, 10, 1, 1, 1);
    $display("test mapping done");
    for (int p = 0; p < 4; p++) begin
      setMode(16'h0001 | 16'(p << 2), 32'h1);
      burst(0, 10, 8, 8 >> p, 0);
    end
    setMode(16'h0005, 32'h1);
    burst(0, 10, 1, 0, 0);
    wr(aEn, 32'h0);
    wr(aEn, 32'h1);
    burst(0, 10, 1, 0, 0);
    burst(0, 10, 1, 1, 0);
    setMode(16'h0001, 32'h3);
    cap1 = 0;
    pm.setLine(0, 1'b1);
    repeat (20) @(posedge clk);
    `CHK("rising ignored", 0, cap1)
    burst(0, 10, 1, 1, 0);
    $display("test prescaler done");
    for (int f = 0; f < 3; f++) begin
      setMode(16'h0001 | 16'(fc[f] << 4), 32'h1);
      burst(0, sl[f], 1, 0, 0);
      burst(0, ll[f], 1, 1, 0);
    end
    $display("test filter done");
    wr(aEn, 32'h0);
    for (int k = 0; k < 5; k++) begin
      wr(aMode, {16'h0, fm[k]});
      repeat (10) @(posedge clk);
      trigLat(oc, ts);
      `CHK("forced output", fe[k], oc)
      `CHK("trigger start", 4, ts)
    end
    pm.setLine(3, 1'b1);
    repeat (2) @(posedge clk);
    `CHK("compare level", 1'b1, ch1OcRef)
    pm.setLine(3, 1'b0);
    $display("test trigger done");
    wrapUp();
  end
endmodule : tccm_mode_config_tb
